// ==== src/spm_pkg.sv ====
/*
 * Constants for the servo P/PI mode switch block: register offsets, reset values,
 * field codes and the control-cycle timing.
 * Assumes a 200 MHz system clock and Avalon-MM register access with 32-bit data.
 */
package spm_pkg;
	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [5:0] OFS_SPD_DET_SEL   = 6'h00;
	localparam logic [5:0] OFS_FF_GAIN       = 6'h04;
	localparam logic [5:0] OFS_FF_FILT       = 6'h08;
	localparam logic [5:0] OFS_MS_COND       = 6'h0C;
	localparam logic [5:0] OFS_TRQ_THR       = 6'h10;
	localparam logic [5:0] OFS_SPD_THR       = 6'h14;
	localparam logic [5:0] OFS_ACC_THR       = 6'h18;
	localparam logic [5:0] OFS_PERR_THR      = 6'h1C;
	localparam logic [5:0] OFS_CTRL          = 6'h20;
	localparam logic [5:0] OFS_STATUS        = 6'h24;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] RST_SPD_DET_SEL  = 16'h0000;
	localparam logic [15:0] RST_FF_GAIN      = 16'h0000;
	localparam logic [15:0] RST_FF_FILT      = 16'h0000;
	localparam logic [15:0] RST_MS_COND      = 16'h0000;
	localparam logic [15:0] RST_TRQ_THR      = 16'h00C8;
	localparam logic [15:0] RST_SPD_THR      = 16'h0000;
	localparam logic [15:0] RST_ACC_THR      = 16'h0000;
	localparam logic [15:0] RST_PERR_THR     = 16'h0000;
	// ****************************************
	// Fields
	// ****************************************
	localparam int          SPD_DET_BIT      = 8;
	localparam int          CTRL_POSMODE_BIT = 0;
	localparam int          CTRL_IP_BIT      = 1;
	localparam int          CTRL_RESTART_BIT = 2;
	localparam logic [15:0] FF_GAIN_MAX      = 16'h0064;
	localparam logic [15:0] FF_FILT_MAX      = 16'h1900;
	localparam logic [15:0] TRQ_THR_MAX      = 16'h0320;
	localparam logic [15:0] SPD_THR_MAX      = 16'h2710;
	localparam logic [15:0] ACC_THR_MAX      = 16'h7530;
	localparam logic [15:0] PERR_THR_MAX     = 16'h2710;
	typedef enum logic [2:0] {
		SPM_SRC_TRQ  = 3'b000,
		SPM_SRC_SPD  = 3'b001,
		SPM_SRC_ACC  = 3'b010,
		SPM_SRC_PERR = 3'b011,
		SPM_SRC_OFF  = 3'b100
	} spm_src_t;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ        = 200;
	localparam int FILT_UNIT_NS   = 10000;
	localparam int CYCLE_NS       = 10000;
	localparam int CYCLE_CLKS     = CYCLE_NS * CLK_MHZ / 1000;
	localparam int FILT_UNIT_CLKS = FILT_UNIT_NS * CLK_MHZ / 1000;
endpackage : spm_pkg

// ==== src/spm_tick.sv ====
/*
 * Divider that gives a one-cycle enable pulse every DIV clocks.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module spm_tick #(
	parameter int DIV = 2000
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic reset_n,
	// Enable out
	output logic      tick
);
	logic [15:0] cnt_r;
	wire         wrap = (cnt_r == 16'(DIV - 1));

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			cnt_r <= 16'h0000;
		else
			cnt_r <= wrap ? 16'h0000 : cnt_r + 16'h0001;
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			tick <= 1'b0;
		else
			tick <= wrap;
	end
endmodule : spm_tick

// ==== src/spm_ffilt.sv ====
/*
 * First-order low-pass filter for the feedforward term, updated once per
 * control cycle. Time constant in 0.01 ms units; zero passes the input through.
 * Assumes the control-cycle enable comes from the same clock.
 */
`timescale 1ns/1ps
module spm_ffilt (
	// Clock and reset
	input  wire logic               clk_sys,
	input  wire logic               reset_n,
	// Control
	input  wire logic               cyc_en,
	input  wire logic        [15:0] tconst,
	// Data
	input  wire logic signed [31:0] din,
	output logic signed [31:0]      dout
);
	// Step size is cycle/(tau+cycle); cycle equals one filter unit
	wire logic signed [47:0] diff = 48'(din) - 48'(dout);
	wire logic signed [47:0] step = diff / $signed({31'h0, tconst + 17'h00001});

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			dout <= 32'sh0;
		else if (cyc_en)
			dout <= (tconst == 16'h0000) ? din : dout + 32'(step);
	end
endmodule : spm_ffilt

// ==== src/spm_mode_switch.sv ====
/*
 * Servo control-loop selection: speed detection choice, position feedforward
 * with gain and filter, and P/PI mode switching of the speed loop.
 * Assumes process quantities come from logic on the same clock and registers
 * are reached by an Avalon-MM master with waitrequest.
 */
// Functional notes
// (R1) Speed detection method 1 when select digit is 0, method 2 when 1.
// (R2) Speed detection select changes only take effect after restart.
// (R3) Position control adds feedforward scaled by gain 0..100 percent, immediate.
// (R4) Feedforward low-pass filtered, time constant 0..6400 in 0.01 ms units.
// (R5) Software should keep feedforward gain below 80 percent.
// (R6) Condition field: torque, speed, acceleration, position error, or disabled.
// (R7) I-P speed control disables P/PI switching entirely.
// (R8) Torque reference above threshold (0..800 percent, default 200) selects P.
// (R9) Speed reference above threshold (0..10000) selects P control.
// (R10) Acceleration above threshold (0..30000) selects P control.
// (R11) Position error above threshold (0..10000) selects P control.
// (R12) Position error switching acts only in position control.
// (R13) Threshold changes take effect immediately without restart.
// (R14) Otherwise PI control, comparison re-evaluated every control cycle.
`timescale 1ns/1ps
module spm_mode_switch (
	// Clock and reset
	input  wire logic               clk_sys,
	input  wire logic               reset_n,
	// Avalon-MM slave
	input  wire logic        [5:0]  avs_address,
	input  wire logic               avs_read,
	input  wire logic               avs_write,
	input  wire logic        [31:0] avs_writedata,
	input  wire logic        [3:0]  avs_byteenable,
	output logic             [31:0] avs_readdata,
	output logic                    avs_waitrequest,
	// Process quantities: four magnitudes and a signed position reference difference
	input  wire logic        [15:0] torque_ref_mag,
	input  wire logic        [15:0] speed_ref_mag,
	input  wire logic        [15:0] accel_mag,
	input  wire logic        [15:0] pos_err_mag,
	input  wire logic signed [31:0] pos_ref_diff,
	// Loop outputs
	output logic                    p_ctrl_sel,
	output logic                    speed_det2_sel,
	output logic signed [31:0]      feedforward_out
);
	// ****************************************
	// Registers
	// ****************************************
	logic [15:0] speed_detect_select_r;
	logic [15:0] feedforward_gain_r;
	logic [15:0] feedforward_filter_time_r;
	logic [15:0] mode_switch_condition_r;
	logic [15:0] torque_switch_threshold_r;
	logic [15:0] speed_switch_threshold_r;
	logic [15:0] accel_switch_threshold_r;
	logic [15:0] poserr_switch_threshold_r;
	logic [2:0]  ctrl_r;
	logic        ack_r;
	logic        cyc_en;
	logic signed [31:0] ff_filt;

	// Bus access: one wait cycle, answer on second cycle
	wire acc       = (avs_read | avs_write) & ~ack_r;
	wire wr_en     = avs_write & ack_r;
	wire wr_lo     = wr_en & avs_byteenable[0];
	wire wr_hi     = wr_en & avs_byteenable[1];
	wire sel_sds   = (avs_address == spm_pkg::OFS_SPD_DET_SEL);
	wire sel_ffg   = (avs_address == spm_pkg::OFS_FF_GAIN);
	wire sel_fft   = (avs_address == spm_pkg::OFS_FF_FILT);
	wire sel_msc   = (avs_address == spm_pkg::OFS_MS_COND);
	wire sel_trq   = (avs_address == spm_pkg::OFS_TRQ_THR);
	wire sel_spd   = (avs_address == spm_pkg::OFS_SPD_THR);
	wire sel_acc   = (avs_address == spm_pkg::OFS_ACC_THR);
	wire sel_perr  = (avs_address == spm_pkg::OFS_PERR_THR);
	wire sel_ctrl  = (avs_address == spm_pkg::OFS_CTRL);
	wire sel_stat  = (avs_address == spm_pkg::OFS_STATUS);
	wire [15:0] wd = avs_writedata[15:0];

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
		input logic lo, input logic hi);
		merge = {hi ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
	endfunction : merge

	// Gain, filter time and threshold writes outside the documented range clamp to the maximum
	function automatic logic [15:0] clampv(input logic [15:0] v, input logic [15:0] mx);
		clampv = (v > mx) ? mx : v;
	endfunction : clampv

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			ack_r <= 1'b0;
		else
			ack_r <= acc;
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			speed_detect_select_r     <= spm_pkg::RST_SPD_DET_SEL;
			feedforward_gain_r        <= spm_pkg::RST_FF_GAIN;
			feedforward_filter_time_r <= spm_pkg::RST_FF_FILT;
			mode_switch_condition_r   <= spm_pkg::RST_MS_COND;
			torque_switch_threshold_r <= spm_pkg::RST_TRQ_THR;
			speed_switch_threshold_r  <= spm_pkg::RST_SPD_THR;
			accel_switch_threshold_r  <= spm_pkg::RST_ACC_THR;
			poserr_switch_threshold_r <= spm_pkg::RST_PERR_THR;
			ctrl_r                    <= 3'h0;
		end
		else
		begin
			if (sel_sds)
				speed_detect_select_r <= merge(speed_detect_select_r, wd, wr_lo, wr_hi);
			if (sel_ffg & (wr_lo | wr_hi)) // R3
				feedforward_gain_r <= clampv(merge(feedforward_gain_r, wd, wr_lo, wr_hi),
					spm_pkg::FF_GAIN_MAX);
			if (sel_fft & (wr_lo | wr_hi)) // R4
				feedforward_filter_time_r <= clampv(merge(feedforward_filter_time_r, wd,
					wr_lo, wr_hi), spm_pkg::FF_FILT_MAX);
			if (sel_msc)
				mode_switch_condition_r <= merge(mode_switch_condition_r, wd, wr_lo, wr_hi);
			if (sel_trq & (wr_lo | wr_hi)) // R13
				torque_switch_threshold_r <= clampv(merge(torque_switch_threshold_r, wd,
					wr_lo, wr_hi), spm_pkg::TRQ_THR_MAX);
			if (sel_spd & (wr_lo | wr_hi))
				speed_switch_threshold_r <= clampv(merge(speed_switch_threshold_r, wd,
					wr_lo, wr_hi), spm_pkg::SPD_THR_MAX);
			if (sel_acc & (wr_lo | wr_hi))
				accel_switch_threshold_r <= clampv(merge(accel_switch_threshold_r, wd,
					wr_lo, wr_hi), spm_pkg::ACC_THR_MAX);
			if (sel_perr & (wr_lo | wr_hi))
				poserr_switch_threshold_r <= clampv(merge(poserr_switch_threshold_r, wd,
					wr_lo, wr_hi), spm_pkg::PERR_THR_MAX);
			if (sel_ctrl & wr_lo)
				ctrl_r <= wd[2:0];
			else
				ctrl_r[spm_pkg::CTRL_RESTART_BIT] <= 1'b0;
		end
	end

	// ****************************************
	// Speed detection, latched at restart
	// ****************************************
	// Software restart bit reloads it, so a live write cannot glitch the loop
	wire restart = ctrl_r[spm_pkg::CTRL_RESTART_BIT];
	logic boot_r;
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			boot_r <= 1'b1;
		else
			boot_r <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			speed_det2_sel <= 1'b0;
		else if (boot_r | restart) // R2
			speed_det2_sel <= speed_detect_select_r[spm_pkg::SPD_DET_BIT]; // R1
	end

	// ****************************************
	// Mode switch decision
	// ****************************************
	spm_tick #(.DIV(spm_pkg::CYCLE_CLKS)) u_tick (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.tick    (cyc_en)
	);

	wire pos_mode = ctrl_r[spm_pkg::CTRL_POSMODE_BIT];
	wire ip_mode  = ctrl_r[spm_pkg::CTRL_IP_BIT];
	wire [2:0] cond = mode_switch_condition_r[2:0];
	wire over_trq  = torque_ref_mag > torque_switch_threshold_r; // R8
	wire over_spd  = speed_ref_mag > speed_switch_threshold_r; // R9
	wire over_acc  = accel_mag > accel_switch_threshold_r; // R10
	wire over_perr = pos_mode & (pos_err_mag > poserr_switch_threshold_r); // R11 R12
	wire cond_hit  = (cond == spm_pkg::SPM_SRC_TRQ)  ? over_trq : // R6
	                 (cond == spm_pkg::SPM_SRC_SPD)  ? over_spd :
	                 (cond == spm_pkg::SPM_SRC_ACC)  ? over_acc :
	                 (cond == spm_pkg::SPM_SRC_PERR) ? over_perr : 1'b0;
	wire p_nxt     = cond_hit & ~ip_mode; // R7

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			p_ctrl_sel <= 1'b0;
		else if (cyc_en)
			p_ctrl_sel <= p_nxt; // R14
	end

	// ****************************************
	// Feedforward
	// ****************************************
	// Gain is a percentage; divide after the product to keep resolution
	wire logic signed [47:0] ff_prod = 48'(pos_ref_diff) * $signed({1'b0, feedforward_gain_r});
	wire logic signed [31:0] ff_raw  = pos_mode ? 32'(ff_prod / 48'sd100) : 32'sh0; // R3

	spm_ffilt u_ffilt (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.cyc_en  (cyc_en),
		.tconst  (feedforward_filter_time_r),
		.din     (ff_raw),
		.dout    (ff_filt)
	);

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			feedforward_out <= 32'sh0;
		else
			feedforward_out <= ff_filt; // R4
	end

	// ****************************************
	// Read path
	// ****************************************
	wire [15:0] rd_mux =
		sel_sds  ? speed_detect_select_r :
		sel_ffg  ? feedforward_gain_r :
		sel_fft  ? feedforward_filter_time_r :
		sel_msc  ? mode_switch_condition_r :
		sel_trq  ? torque_switch_threshold_r :
		sel_spd  ? speed_switch_threshold_r :
		sel_acc  ? accel_switch_threshold_r :
		sel_perr ? poserr_switch_threshold_r :
		sel_ctrl ? {13'h0000, ctrl_r} :
		sel_stat ? {14'h0000, speed_det2_sel, p_ctrl_sel} : 16'h0000;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read & ~ack_r)
			avs_readdata <= {16'h0000, rd_mux};
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= ~acc;
	end

	// ****************************************
	// Checks
	// ****************************************
	a_ip_blocks_p: assert property (@(posedge clk_sys) disable iff (!reset_n) // R7
		(cyc_en && ip_mode) |=> !p_ctrl_sel) else $error("P control while I-P selected");
	a_off_keeps_pi: assert property (@(posedge clk_sys) disable iff (!reset_n) // R6
		(cyc_en && cond == 3'b100) |=> !p_ctrl_sel) else $error("P control while disabled");
	a_trq_switch: assert property (@(posedge clk_sys) disable iff (!reset_n) // R8
		(cyc_en && !ip_mode && cond == 3'b000 && torque_ref_mag > torque_switch_threshold_r)
		|=> p_ctrl_sel) else $error("Torque over threshold without P");
	a_spd_switch: assert property (@(posedge clk_sys) disable iff (!reset_n) // R9
		(cyc_en && !ip_mode && cond == 3'b001 && speed_ref_mag > speed_switch_threshold_r)
		|=> p_ctrl_sel) else $error("Speed over threshold without P");
	a_acc_switch: assert property (@(posedge clk_sys) disable iff (!reset_n) // R10
		(cyc_en && !ip_mode && cond == 3'b010 && accel_mag > accel_switch_threshold_r)
		|=> p_ctrl_sel) else $error("Accel over threshold without P");
	a_perr_posonly: assert property (@(posedge clk_sys) disable iff (!reset_n) // R12
		(cyc_en && cond == 3'b011 && !pos_mode) |=> !p_ctrl_sel)
		else $error("Position error switching outside position control");
	a_perr_switch: assert property (@(posedge clk_sys) disable iff (!reset_n) // R11
		(cyc_en && !ip_mode && pos_mode && cond == 3'b011 &&
		pos_err_mag > poserr_switch_threshold_r) |=> p_ctrl_sel)
		else $error("Position error over threshold without P");
	a_pi_default: assert property (@(posedge clk_sys) disable iff (!reset_n) // R14
		(cyc_en && !p_nxt) |=> !p_ctrl_sel) else $error("P control without cause");
	a_hold_between: assert property (@(posedge clk_sys) disable iff (!reset_n) // R14
		!cyc_en |=> $stable(p_ctrl_sel)) else $error("Mode changed between cycles");
	a_det_restart: assert property (@(posedge clk_sys) disable iff (!reset_n) // R2
		(!boot_r && !restart) |=> $stable(speed_det2_sel))
		else $error("Detection method changed without restart");
	a_gain_limit: assert property (@(posedge clk_sys) disable iff (!reset_n) // R3
		feedforward_gain_r <= spm_pkg::FF_GAIN_MAX) else $error("Feedforward gain above range");
	a_cond_spare: assert property (@(posedge clk_sys) disable iff (!reset_n) // R6
		(cyc_en && cond > 3'b100) |=> !p_ctrl_sel) else $error("P control on spare code");

	// ****************************************
	// Bus and output checks
	// ****************************************
	// A fresh request: read or write seen while no answer is pending
	sequence s_bus_req;
		(avs_read || avs_write) && !ack_r;
	endsequence : s_bus_req

	// Exactly one low cycle of waitrequest, then high again
	sequence s_bus_answer;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence : s_bus_answer

	a_bus_one_wait: assert property (@(posedge clk_sys) disable iff (!reset_n)
		s_bus_req |=> s_bus_answer) else $error("Bus answer is not one wait state");
	a_read_data: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(avs_read && !ack_r) |=> (avs_readdata == {16'h0000, $past(rd_mux)}))
		else $error("Read data does not match the addressed register");
	a_det_reload: assert property (@(posedge clk_sys) disable iff (!reset_n) // R1
		restart |=> (speed_det2_sel == $past(speed_detect_select_r[spm_pkg::SPD_DET_BIT])))
		else $error("Detection method not reloaded at restart");
	a_ff_passthru: assert property (@(posedge clk_sys) disable iff (!reset_n) // R4
		(cyc_en && feedforward_filter_time_r == 16'h0000)
		|=> ##1 (feedforward_out == $past(ff_raw, 2)))
		else $error("Unfiltered feedforward not passed through");
endmodule : spm_mode_switch

// ==== test/spm_mode_switch_test.sv ====
/*
 * Self-checking bench for spm_mode_switch: register defaults, clamping, byte lanes,
 * restart-gated speed detection, P/PI switching per condition, feedforward gain.
 * Assumes the 10 us control tick of the design and one wait state on the register bus.
 */
`timescale 1ns/1ps
module spm_mode_switch_test;
	// ****************************************
	// Signals
	// ****************************************
	logic               clk_sys;
	logic               reset_n;
	logic        [5:0]  avs_address;
	logic               avs_read;
	logic               avs_write;
	logic        [31:0] avs_writedata;
	logic        [3:0]  avs_byteenable;
	logic        [31:0] avs_readdata;
	logic               avs_waitrequest;
	logic        [15:0] torque_ref_mag;
	logic        [15:0] speed_ref_mag;
	logic        [15:0] accel_mag;
	logic        [15:0] pos_err_mag;
	logic signed [31:0] pos_ref_diff;
	logic               p_ctrl_sel;
	logic               speed_det2_sel;
	logic signed [31:0] feedforward_out;
	int                 failures;
	int                 checks_done;
	int                 cyc;
	int                 seed;
	int                 thr[4];
	int                 val[4];
	int                 diff;
	int                 ff_exp;
	int                 ff_in;
	int                 gains[3] = '{0, 37, 79};
	logic        [31:0] rd;
	logic               pe;
	logic        [5:0]  ofs_v[8] = '{spm_pkg::OFS_SPD_DET_SEL, spm_pkg::OFS_FF_GAIN,
		spm_pkg::OFS_FF_FILT, spm_pkg::OFS_MS_COND, spm_pkg::OFS_TRQ_THR,
		spm_pkg::OFS_SPD_THR, spm_pkg::OFS_ACC_THR, spm_pkg::OFS_PERR_THR};
	logic        [15:0] rst_v[8] = '{spm_pkg::RST_SPD_DET_SEL, spm_pkg::RST_FF_GAIN,
		spm_pkg::RST_FF_FILT, spm_pkg::RST_MS_COND, spm_pkg::RST_TRQ_THR,
		spm_pkg::RST_SPD_THR, spm_pkg::RST_ACC_THR, spm_pkg::RST_PERR_THR};
	logic        [15:0] max_v[8] = '{16'h0000, spm_pkg::FF_GAIN_MAX, spm_pkg::FF_FILT_MAX,
		16'h0000, spm_pkg::TRQ_THR_MAX, spm_pkg::SPD_THR_MAX, spm_pkg::ACC_THR_MAX,
		spm_pkg::PERR_THR_MAX};

	spm_mode_switch u_dut (
		.clk_sys         (clk_sys),
		.reset_n         (reset_n),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_byteenable  (avs_byteenable),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.torque_ref_mag  (torque_ref_mag),
		.speed_ref_mag   (speed_ref_mag),
		.accel_mag       (accel_mag),
		.pos_err_mag     (pos_err_mag),
		.pos_ref_diff    (pos_ref_diff),
		.p_ctrl_sel      (p_ctrl_sel),
		.speed_det2_sel  (speed_det2_sel),
		.feedforward_out (feedforward_out)
	);

	always #2.5 clk_sys = ~clk_sys;

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// Holds the request until waitrequest is sampled low, releases it there, idles one edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d,
		input logic [3:0] be);
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= ~wr;
		do
			@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask : bus

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	// Reference of the P/PI decision, strictly greater-than
	function automatic logic mode_exp(input int c, input logic ip, input logic pos);
		if (ip)
			return 1'b0;
		case (c)
			0: return val[0] > thr[0];
			1: return val[1] > thr[1];
			2: return val[2] > thr[2];
			3: return pos && (val[3] > thr[3]);
			default: return 1'b0;
		endcase
	endfunction : mode_exp

	// ****************************************
	// Timeout
	// ****************************************
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 95000)
		begin
			failures++;
			$display("[ERR] run length expected below 95000 seen %0d", cyc);
			close_out();
		end
	end

	// ****************************************
	// Sequence
	// ****************************************
	initial
	begin
		seed = 32'hf519949e;
		clk_sys = 1'b0;
		reset_n = 1'b0;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h0;
		torque_ref_mag = 16'h0000;
		speed_ref_mag = 16'h0000;
		accel_mag = 16'h0000;
		pos_err_mag = 16'h0000;
		pos_ref_diff = 32'sh0000_0000;
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 8; i++)
		begin
			bus(1'b0, ofs_v[i], 16'h0000, 4'hF);
			chk("reset value", {16'h0000, rst_v[i]}, rd);
		end
		// Values above the range clamp to the top of the range
		for (int i = 1; i < 8; i++)
		begin
			if (i != 3)
			begin
				bus(1'b1, ofs_v[i], 16'hFFFF, 4'h3);
				bus(1'b0, ofs_v[i], 16'h0000, 4'hF);
				chk("clamped value", {16'h0000, max_v[i]}, rd);
			end
		end
		bus(1'b1, 6'h28, 16'h1234, 4'h3);
		bus(1'b0, 6'h28, 16'h0000, 4'hF);
		chk("unmapped read", 32'h0, rd);
		bus(1'b1, spm_pkg::OFS_TRQ_THR, 16'h0155, 4'h3);
		bus(1'b1, spm_pkg::OFS_TRQ_THR, 16'h02AA, 4'h1);
		bus(1'b0, spm_pkg::OFS_TRQ_THR, 16'h0000, 4'hF);
		chk("low lane write", 32'h0000_01AA, rd);
		// Speed detection choice waits for a restart
		bus(1'b1, spm_pkg::OFS_SPD_DET_SEL, 16'h0100, 4'h3);
		repeat (5) @(posedge clk_sys);
		chk("det2 before restart", 32'h0, {31'h0, speed_det2_sel});
		bus(1'b1, spm_pkg::OFS_CTRL, 16'h0004, 4'h3);
		repeat (5) @(posedge clk_sys);
		chk("det2 after restart", 32'h1, {31'h0, speed_det2_sel});
		bus(1'b1, spm_pkg::OFS_SPD_DET_SEL, 16'h0000, 4'h3);
		bus(1'b1, spm_pkg::OFS_CTRL, 16'h0004, 4'h3);
		repeat (5) @(posedge clk_sys);
		chk("det1 after restart", 32'h0, {31'h0, speed_det2_sel});
		// Thresholds near the inputs so both sides of each compare are hit
		for (int i = 0; i < 16; i++)
		begin
			for (int k = 0; k < 4; k++)
			begin
				thr[k] = 1 + ($random(seed) & 32'h1FF);
				val[k] = thr[k] - 1 + ($random(seed) & 32'h3);
				bus(1'b1, ofs_v[4 + k], 16'(thr[k]), 4'h3);
			end
			bus(1'b1, spm_pkg::OFS_MS_COND, 16'(i % 6), 4'h3);
			bus(1'b1, spm_pkg::OFS_CTRL, {14'h0, i == 12 || i == 14, i >= 6 && i < 12}, 4'h3);
			torque_ref_mag <= 16'(val[0]);
			speed_ref_mag <= 16'(val[1]);
			accel_mag <= 16'(val[2]);
			pos_err_mag <= 16'(val[3]);
			repeat (4100) @(posedge clk_sys);
			pe = mode_exp(i % 6, i == 12 || i == 14, i >= 6 && i < 12);
			chk("p_ctrl_sel", {31'h0, pe}, {31'h0, p_ctrl_sel});
			bus(1'b0, spm_pkg::OFS_STATUS, 16'h0000, 4'hF);
			chk("status p bit", {31'h0, pe}, {31'h0, rd[0]});
		end
		// Feedforward with no filtering passes diff times gain percent
		bus(1'b1, spm_pkg::OFS_FF_FILT, 16'h0000, 4'h3);
		for (int g = 0; g < 3; g++)
		begin
			diff = $random(seed) & 32'hFFFF;
			pos_ref_diff <= diff;
			bus(1'b1, spm_pkg::OFS_FF_GAIN, 16'(gains[g]), 4'h3);
			bus(1'b1, spm_pkg::OFS_CTRL, 16'h0001, 4'h3);
			repeat (4100) @(posedge clk_sys);
			chk("feedforward", 32'(diff * gains[g] / 100), feedforward_out);
		end
		// A step below one count must leave the slow filter where it stands
		bus(1'b1, spm_pkg::OFS_FF_FILT, spm_pkg::FF_FILT_MAX, 4'h3);
		pos_ref_diff <= diff + 100;
		repeat (4100) @(posedge clk_sys);
		ff_exp = diff * gains[2] / 100;
		ff_in = (diff + 100) * gains[2] / 100;
		ff_exp = ff_exp + (ff_in - ff_exp) / (int'(spm_pkg::FF_FILT_MAX) + 1);
		chk("filtered feedforward", 32'(ff_exp), feedforward_out);
		bus(1'b1, spm_pkg::OFS_FF_FILT, 16'h0000, 4'h3);
		bus(1'b1, spm_pkg::OFS_CTRL, 16'h0000, 4'h3);
		repeat (4100) @(posedge clk_sys);
		chk("feedforward off", 32'h0, feedforward_out);
		close_out();
	end
endmodule : spm_mode_switch_test
